// ===== eirq_pkg.sv
// Purpose: shared constants and types of the ethernet interrupt and diagnostics block
// Assumes: one 200 MHz clock, register offsets are byte addresses of 32-bit words
// Notes: function index 0 is dma, 1 is receive, 2 is transmit
package eirq_pkg;
	localparam int CLK_NS = 5;
	localparam int AW = 8;
	localparam int DW = 16;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_CFG2 = 8'h08;
	// ------------------------------------------------------------
	// command register fields
	// ------------------------------------------------------------
	localparam int CMD_IE_LSB = 0;
	localparam int CMD_ACK_LSB = 4;
	localparam int CMD_ON_LSB = 8;
	localparam int CMD_OFF_LSB = 12;
	localparam int FN_DMA = 0;
	localparam int FN_RX = 1;
	localparam int FN_TX = 2;
	// ------------------------------------------------------------
	// status register fields
	// ------------------------------------------------------------
	localparam int ST_DMA = 4;
	localparam int ST_RX = 5;
	localparam int ST_TX = 6;
	localparam int ST_BUSY = 7;
	localparam int ST_ON_LSB = 8;
	// ------------------------------------------------------------
	// second configuration register fields
	// ------------------------------------------------------------
	localparam int CF_PROM = 2;
	localparam int CF_ERR_LSB = 3;
	localparam int CF_BADCRC = 9;
	localparam int CF_KEEPCRC = 10;
	localparam int CF_LOOP = 11;
	localparam logic [15:0] CFG2_RST = 16'h0000;
	// ------------------------------------------------------------
	// transmit header command byte report bits
	// ------------------------------------------------------------
	localparam int RP_BABBLE = 0;
	localparam int RP_COLL = 1;
	localparam int RP_COLL16 = 2;
	localparam int RP_OK = 3;
	// ------------------------------------------------------------
	// frame limits and timing
	// ------------------------------------------------------------
	localparam logic [10:0] MAX_FRAME = 11'd1514;
	localparam logic [4:0] COLL_LIMIT = 5'd16;
	localparam logic [3:0] BO_EXP_MAX = 4'd10;
	localparam int SLOT_NS = 51200;
	localparam int SLOT_CYC = SLOT_NS / CLK_NS;
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_SEND = 3'b010,
		TX_WAIT = 3'b100
	} eirq_tx_t;
	typedef struct packed {
		logic [2:0] err;
		logic match;
		logic pre_coll;
	} eirq_rxst_t;
endpackage

// ===== eirq_top.sv
// Purpose: interrupt sources, transmit retry control and diagnostic bits of an ethernet controller
// Assumes: all inputs synchronous to I_CLK, register port as address, data, strobes
// Notes: flags are sticky; a new event in the cycle of its acknowledge keeps the flag set
//
// What this block does
// - flag babble when sent frame exceeds 1514 bytes
// - collision rewinds pointer, retries after backoff
// - per-collision reporting sets transmit flag each time
// - sixteenth collision reports, abandons, moves to next
// - success reported when under sixteen collisions
// - accepted stored frame sets receive flag bit 5
// - receive flag and interrupt hold until acknowledge
// - new receive event beats simultaneous acknowledge
// - dma terminal count sets dma flag
// - dma interrupt only when enable bit 0 set
// - writing one to dma acknowledge clears flag
// - config bit 11 drives loopback control low
// - looped-back matching frames stored like others
// - bits 9, 10 force bad crc, keep crc
// - on and off together force function flag
// - forced test leaves frame traffic untouched
// - no transmit start while receiving; receive while sending
// - preamble collision frames always rejected
// - config bits 3-5 accept frames with errors
// - transmit events report only if header selects
// - transmit enable bit 2 routes flag to interrupt
// - acknowledge bit 6 clears transmit flag
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module eirq_top import eirq_pkg::*; #(
	parameter int P_SLOT_CYC = SLOT_CYC
) (
	input wire logic I_CLK, // system clock
	input wire logic I_RST_B, // async reset, active low
	input wire logic [AW-1:0] I_ADDR, // register byte address
	input wire logic [DW-1:0] I_WDATA, // register write data
	input wire logic I_WR, // write strobe
	input wire logic I_RD, // read strobe
	output logic [DW-1:0] O_RDATA, // read data, cycle after strobe
	input wire logic I_TX_REQ, // a frame is queued for sending
	input wire logic [3:0] I_TX_CMD, // header command byte report bits
	input wire logic I_TX_BYTE, // one byte sent
	input wire logic I_TX_COLL, // collision seen while sending
	input wire logic I_TX_END, // frame finished on the wire
	input wire logic I_RX_BUSY, // receiver is taking a frame
	input wire logic I_RX_END, // received frame complete
	input wire eirq_rxst_t I_RX_ST, // status of completed frame
	input wire logic I_DMA_TC, // terminal count from dma controller
	output logic O_TX_GO, // start or restart a frame, pulse
	output logic O_TX_REWIND, // rewind pointer to frame start, pulse
	output logic O_TX_ABANDON, // drop frame, go to next, pulse
	output logic O_TX_DONE, // frame sent, pulse
	output logic O_RX_KEEP, // keep frame in buffer, pulse
	output logic O_RX_DROP, // discard frame, pulse
	output logic O_BAD_CRC, // send frames with corrupted crc
	output logic O_KEEP_CRC, // store received crc with frame
	output logic O_LOOPBACK_N, // converter loopback, active low
	output logic [2:0] O_FN_ON, // dma, receive, transmit enabled
	output logic O_IRQ // interrupt request
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] ie;
		logic [2:0] flag;
		logic [2:0] on;
		logic [15:0] cfg;
		logic [DW-1:0] rdata;
		logic irq;
		eirq_tx_t tx;
		logic [3:0] rep;
		logic [4:0] coll;
		logic [10:0] bytes;
		logic [9:0] slots;
		logic [15:0] timer;
		logic [15:0] lfsr;
		logic go;
		logic rewind;
		logic abandon;
		logic done;
		logic keep;
		logic drop;
	} eirq_st_t;

	eirq_st_t s_q;
	eirq_st_t s_d;

	logic wr_cmd;
	logic wr_cfg;
	logic [2:0] ev;
	logic [2:0] ack;
	logic [2:0] cmd_on;
	logic [2:0] cmd_off;
	logic [2:0] forced;
	logic [4:0] coll_nx;
	logic [3:0] bo_exp;
	logic [9:0] bo_mask;
	logic rx_ok;
	logic slot_end;
	logic [15:0] stat;

	assign wr_cmd = I_WR && (I_ADDR == OFS_CMD);
	assign wr_cfg = I_WR && (I_ADDR == OFS_CFG2);
	assign ack = wr_cmd ? I_WDATA[CMD_ACK_LSB +: 3] : 3'h0;
	assign cmd_on = wr_cmd ? I_WDATA[CMD_ON_LSB +: 3] : 3'h0;
	assign cmd_off = wr_cmd ? I_WDATA[CMD_OFF_LSB +: 3] : 3'h0;
	// both on and off at once only tests the interrupt path
	assign forced = cmd_on & cmd_off;
	assign coll_nx = s_q.coll + 5'h01;
	assign bo_exp = (coll_nx > {1'b0, BO_EXP_MAX}) ? BO_EXP_MAX : coll_nx[3:0];
	// truncated binary exponential backoff window
	assign bo_mask = ~(10'h3FF << bo_exp);
	assign slot_end = (s_q.timer == 16'h0000);

	// a preamble collision loses the frame whatever errors are allowed
	assign rx_ok = s_q.on[FN_RX] && !I_RX_ST.pre_coll
		&& (I_RX_ST.match || s_q.cfg[CF_PROM])
		&& ((I_RX_ST.err & ~s_q.cfg[CF_ERR_LSB +: 3]) == 3'h0);

	always_comb begin
		stat = 16'h0000;
		stat[ST_DMA] = s_q.flag[FN_DMA];
		stat[ST_RX] = s_q.flag[FN_RX];
		stat[ST_TX] = s_q.flag[FN_TX];
		stat[ST_BUSY] = (s_q.tx != TX_IDLE);
		stat[ST_ON_LSB +: 3] = s_q.on;
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		ev = forced;
		s_d.go = 1'b0;
		s_d.rewind = 1'b0;
		s_d.abandon = 1'b0;
		s_d.done = 1'b0;
		s_d.keep = 1'b0;
		s_d.drop = 1'b0;
		s_d.lfsr = {s_q.lfsr[14:0], s_q.lfsr[15] ^ s_q.lfsr[13] ^ s_q.lfsr[12] ^ s_q.lfsr[10]};

		// register writes
		if (wr_cmd) begin
			s_d.ie = I_WDATA[CMD_IE_LSB +: 3];
		end
		if (wr_cfg) begin
			s_d.cfg = I_WDATA;
		end
		// forced test keeps the functions as they were
		s_d.on = (s_q.on | (cmd_on & ~cmd_off)) & ~(cmd_off & ~cmd_on);

		// register reads
		s_d.rdata = {DW{1'b0}};
		if (I_RD) begin
			if (I_ADDR == OFS_CMD) begin
				s_d.rdata[CMD_IE_LSB +: 3] = s_q.ie;
				s_d.rdata[CMD_ON_LSB +: 3] = s_q.on;
			end else if (I_ADDR == OFS_STAT) begin
				s_d.rdata = stat;
			end else if (I_ADDR == OFS_CFG2) begin
				s_d.rdata = s_q.cfg;
			end else begin
				s_d.rdata = {DW{1'b0}};
			end
		end

		// receive path runs whatever the transmitter does
		if (I_RX_END) begin
			s_d.keep = rx_ok;
			s_d.drop = !rx_ok;
			if (rx_ok) begin
				ev[FN_RX] = 1'b1;
			end
		end

		if (I_DMA_TC) begin
			ev[FN_DMA] = 1'b1;
		end

		// transmit sequencing
		case (s_q.tx)
			TX_IDLE: begin
				// never start over a frame being received
				if (I_TX_REQ && s_q.on[FN_TX] && !I_RX_BUSY) begin
					s_d.go = 1'b1;
					s_d.rep = I_TX_CMD;
					s_d.coll = 5'h00;
					s_d.bytes = 11'h000;
					s_d.tx = TX_SEND;
				end
			end
			TX_SEND: begin
				if (I_TX_COLL) begin
					s_d.coll = coll_nx;
					s_d.rewind = 1'b1;
					s_d.bytes = 11'h000;
					if (s_q.rep[RP_COLL]) begin
						ev[FN_TX] = 1'b1;
					end
					if (coll_nx == COLL_LIMIT) begin
						s_d.abandon = 1'b1;
						if (s_q.rep[RP_COLL16]) begin
							ev[FN_TX] = 1'b1;
						end
						s_d.tx = TX_IDLE;
					end else begin
						s_d.slots = s_q.lfsr[9:0] & bo_mask;
						s_d.timer = 16'(P_SLOT_CYC - 1);
						s_d.tx = TX_WAIT;
					end
				end else if (I_TX_END) begin
					s_d.done = 1'b1;
					// byte count saturates well above the limit
					if (s_q.rep[RP_BABBLE] && (s_q.bytes > MAX_FRAME)) begin
						ev[FN_TX] = 1'b1;
					end
					if (s_q.rep[RP_OK]) begin
						ev[FN_TX] = 1'b1;
					end
					s_d.tx = TX_IDLE;
				end else if (I_TX_BYTE && (s_q.bytes != 11'h7FF)) begin
					s_d.bytes = s_q.bytes + 11'h001;
				end
			end
			TX_WAIT: begin
				if (!slot_end) begin
					s_d.timer = s_q.timer - 16'h0001;
				end else if (s_q.slots != 10'h000) begin
					s_d.slots = s_q.slots - 10'h001;
					s_d.timer = 16'(P_SLOT_CYC - 1);
				end else if (!I_RX_BUSY) begin
					// backoff over; defer while the line carries a frame
					s_d.go = 1'b1;
					s_d.tx = TX_SEND;
				end
			end
			default: begin
				s_d.tx = TX_IDLE;
			end
		endcase

		// a set in the cycle of the acknowledge wins
		s_d.flag = (s_q.flag & ~ack) | ev;
		// interrupt follows the flags one edge later
		s_d.irq = |(s_q.flag & s_q.ie);
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge I_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			s_q.ie <= 3'h0;
			s_q.flag <= 3'h0;
			s_q.on <= 3'h0;
			s_q.cfg <= CFG2_RST;
			s_q.rdata <= {DW{1'b0}};
			s_q.irq <= 1'b0;
			s_q.tx <= TX_IDLE;
			s_q.rep <= 4'h0;
			s_q.coll <= 5'h00;
			s_q.bytes <= 11'h000;
			s_q.slots <= 10'h000;
			s_q.timer <= 16'h0000;
			s_q.lfsr <= LFSR_SEED;
			s_q.go <= 1'b0;
			s_q.rewind <= 1'b0;
			s_q.abandon <= 1'b0;
			s_q.done <= 1'b0;
			s_q.keep <= 1'b0;
			s_q.drop <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign O_RDATA = s_q.rdata;
	assign O_TX_GO = s_q.go;
	assign O_TX_REWIND = s_q.rewind;
	assign O_TX_ABANDON = s_q.abandon;
	assign O_TX_DONE = s_q.done;
	assign O_RX_KEEP = s_q.keep;
	assign O_RX_DROP = s_q.drop;
	assign O_BAD_CRC = s_q.cfg[CF_BADCRC];
	assign O_KEEP_CRC = s_q.cfg[CF_KEEPCRC];
	// the converter loops transmit data back while this is low
	assign O_LOOPBACK_N = !s_q.cfg[CF_LOOP];
	assign O_FN_ON = s_q.on;
	assign O_IRQ = s_q.irq;
endmodule

// ===== eirq_top_props.sv
// Purpose: port checks of eirq_top
// Assumes: one clock, async active-low reset
// Notes: bound to every eirq_top
`timescale 1ns/1ps
module eirq_top_props import eirq_pkg::*; (
	input wire logic I_CLK, // clock
	input wire logic I_RST_B, // reset
	input wire logic I_RD, // read strobe
	input wire logic [DW-1:0] O_RDATA, // read data
	input wire logic I_RX_END, // frame end
	input wire eirq_rxst_t I_RX_ST, // frame status
	input wire logic I_RX_BUSY, // receiving
	input wire logic O_RX_KEEP, // keep
	input wire logic O_RX_DROP, // drop
	input wire logic [2:0] O_FN_ON, // enables
	input wire logic I_TX_COLL, // collision
	input wire logic I_TX_END, // frame sent
	input wire logic O_TX_GO, // start
	input wire logic O_TX_REWIND, // rewind
	input wire logic O_TX_ABANDON, // abandon
	input wire logic O_TX_DONE // done
);
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RST_B);
	chk_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == '0)
		else $error("read data outside its cycle");
	chk_rx_decide: assert property (I_RX_END |=> O_RX_KEEP != O_RX_DROP)
		else $error("frame not decided");
	chk_rx_off: assert property (I_RX_END && !O_FN_ON[FN_RX] |=> O_RX_DROP)
		else $error("frame kept while receiver off");
	chk_precoll_drop: assert property (I_RX_END && I_RX_ST.pre_coll |=> O_RX_DROP)
		else $error("preamble collision frame kept");
	chk_no_go_rx: assert property (O_TX_GO |-> !$past(I_RX_BUSY))
		else $error("start while receiving");
	chk_rewind_cause: assert property (O_TX_REWIND |-> $past(I_TX_COLL))
		else $error("rewind without collision");
	chk_abandon_pair: assert property (O_TX_ABANDON |-> O_TX_REWIND)
		else $error("abandon without rewind");
	chk_done_cause: assert property (O_TX_DONE |-> $past(I_TX_END) && !$past(I_TX_COLL))
		else $error("done without clean end");
	cover property (O_TX_ABANDON);
	cover property (O_RX_KEEP);
	cover property (O_TX_DONE);
endmodule
bind eirq_top eirq_top_props eirq_top_props_inst (.I_CLK, .I_RST_B, .I_RD, .O_RDATA,
	.I_RX_END, .I_RX_ST, .I_RX_BUSY, .O_RX_KEEP, .O_RX_DROP, .O_FN_ON, .I_TX_COLL,
	.I_TX_END, .O_TX_GO, .O_TX_REWIND, .O_TX_ABANDON, .O_TX_DONE);

// ===== eirq_mac_model.sv
// Purpose: transmit line side facing eirq_top
// Assumes: one byte a clock while sending
// Notes: the first nc attempts collide after three bytes
`timescale 1ns/1ps
module eirq_mac_model (
	input wire logic clk, // clock
	input wire logic rst_b, // reset, active low
	input wire logic go, // attempt start
	input wire logic abandon, // frame dropped
	input wire logic [10:0] nb, // frame bytes
	input wire logic [4:0] nc, // colliding attempts
	output logic tx_byte, // byte sent
	output logic tx_coll, // collision
	output logic tx_end // frame finished
);
	logic act;
	logic [10:0] cnt;
	logic [4:0] att;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{act, cnt, att, tx_byte, tx_coll, tx_end} <= '0;
		end else begin
			{tx_byte, tx_coll, tx_end} <= 3'b000;
			if (go) begin
				// a retry restarts from the first byte
				{act, cnt} <= 12'h800;
				att <= att + 5'h01;
			end else if (act) begin
				cnt <= cnt + 11'h001;
				if (att <= nc && cnt == 11'h003) {act, tx_coll} <= 2'b01;
				else if (cnt == nb) {act, tx_end} <= 2'b01;
				else tx_byte <= 1'b1;
			end
			if (abandon || tx_end) att <= 5'h00;
		end
	end
endmodule

// ===== tb_top.sv
// Purpose: self-checking bench of eirq_top
// Assumes: short backoff slot of 4 cycles
// Notes: expected flags come from the event sequence
`timescale 1ns/1ps
module tb_top import eirq_pkg::*;;
	logic clk, rst_b, wr, rd, tx_req, rx_busy, rx_end, dma_tc, tx_byte, tx_coll, tx_end;
	logic go, rew, aband, done, keep, drop, bad_crc, keep_crc, loop_n, irq;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata, rdata, got;
	logic [3:0] tx_cmd;
	logic [2:0] fn_on;
	logic [10:0] nb;
	logic [4:0] nc;
	eirq_rxst_t rx_st;
	int bad_count, compares, gos, i, g;
	eirq_top #(.P_SLOT_CYC(4)) eirq_top_inst (.I_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr),
		.I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_TX_REQ(tx_req),
		.I_TX_CMD(tx_cmd), .I_TX_BYTE(tx_byte), .I_TX_COLL(tx_coll), .I_TX_END(tx_end),
		.I_RX_BUSY(rx_busy), .I_RX_END(rx_end), .I_RX_ST(rx_st), .I_DMA_TC(dma_tc),
		.O_TX_GO(go), .O_TX_REWIND(rew), .O_TX_ABANDON(aband), .O_TX_DONE(done),
		.O_RX_KEEP(keep), .O_RX_DROP(drop), .O_BAD_CRC(bad_crc), .O_KEEP_CRC(keep_crc),
		.O_LOOPBACK_N(loop_n), .O_FN_ON(fn_on), .O_IRQ(irq));
	eirq_mac_model eirq_mac_model_inst (.clk(clk), .rst_b(rst_b), .go(go), .abandon(aband),
		.nb(nb), .nc(nc), .tx_byte(tx_byte), .tx_coll(tx_coll), .tx_end(tx_end));
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) if (go === 1'b1) gos <= gos + 1;
	task complete_run;
		$display("counts bad_count=%0d compares=%0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task chk(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wait_n(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task bus_wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		{wr, addr, wdata} <= {1'b1, a, d};
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task bus_rd(input logic [7:0] a);
		@(posedge clk);
		{rd, addr} <= {1'b1, a};
		@(posedge clk);
		rd <= 1'b0;
		#1 got = rdata;
	endtask
	task st_chk(input string what, input logic [15:0] exp);
		bus_rd(OFS_STAT);
		chk(what, got & 16'h0070, exp);
	endtask
	task rx_frame(input eirq_rxst_t s, input logic k);
		@(posedge clk);
		{rx_end, rx_st} <= {1'b1, s};
		@(posedge clk);
		rx_end <= 1'b0;
		#1 chk("keep", keep, k);
	endtask
	task tx_frame(input logic [3:0] c, input logic [10:0] n, input logic [4:0] k, input logic f);
		@(posedge clk);
		{tx_cmd, nb, nc, tx_req} <= {c, n, k, 1'b1};
		for (i = 0; i < 2000 && go !== 1'b1; i++) wait_n(1);
		@(posedge clk);
		tx_req <= 1'b0;
		for (i = 0; i < 60000 && done !== 1'b1 && aband !== 1'b1; i++) wait_n(1);
		wait_n(3);
		st_chk("tx flag", f ? 16'h0040 : 16'h0000);
		chk("tx irq", irq, f);
		bus_wr(OFS_CMD, 16'h0444);
	endtask
	initial begin
		repeat (90000) @(posedge clk);
		bad_count++;
		complete_run;
	end
	initial begin
		{wr, rd, tx_req, rx_busy, rx_end, dma_tc, rst_b, addr, wdata, tx_cmd, rx_st} = '0;
		{nb, nc, bad_count, compares, gos} = '0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		#1 chk("loop_n", loop_n, 1'b1);
		bus_rd(OFS_CFG2);
		chk("cfg2", got, CFG2_RST);
		bus_rd(8'h0C);
		chk("unmapped", got, 16'h0000);
		st_chk("flags", 16'h0000);
		for (g = 0; g < 2; g++) begin
			bus_wr(OFS_CMD, g ? 16'h0000 : 16'h0101);
			@(posedge clk) dma_tc <= 1'b1;
			@(posedge clk) dma_tc <= 1'b0;
			wait_n(3);
			st_chk("dma flag", 16'h0010);
			chk("dma irq", irq, !g);
			bus_wr(OFS_CMD, 16'h0010);
			wait_n(3);
			st_chk("dma ack", 16'h0000);
			chk("irq low", irq, 1'b0);
		end
		for (g = 0; g < 3; g++) begin
			bus_wr(OFS_CMD, (16'h1100 << g) | (16'h0001 << g));
			wait_n(3);
			st_chk("forced", 16'h0010 << g);
			chk("forced irq", irq, 1'b1);
			chk("fn_on", fn_on, 3'b001);
			bus_wr(OFS_CMD, 16'h0010 << g);
			wait_n(3);
			st_chk("forced ack", 16'h0000);
		end
		bus_wr(OFS_CMD, 16'h0202);
		rx_frame(5'b00010, 1'b1);
		wait_n(40);
		st_chk("rx flag", 16'h0020);
		chk("rx irq", irq, 1'b1);
		// acknowledge in the very cycle of a new frame
		@(posedge clk) {wr, addr, wdata, rx_end, rx_st} <= {1'b1, OFS_CMD, 16'h0222, 6'h22};
		@(posedge clk) {wr, rx_end} <= 2'b00;
		wait_n(3);
		st_chk("rx persist", 16'h0020);
		bus_wr(OFS_CMD, 16'h0222);
		wait_n(3);
		st_chk("rx ack", 16'h0000);
		rx_frame(5'b00000, 1'b0);
		bus_wr(OFS_CFG2, 16'h0E04);
		wait_n(2);
		chk("loop_n", loop_n, 1'b0);
		chk("crc", {bad_crc, keep_crc}, 2'b11);
		rx_frame(5'b00000, 1'b1);
		rx_frame(5'b00110, 1'b0);
		bus_wr(OFS_CFG2, 16'h0E3C);
		rx_frame(5'b11110, 1'b1);
		rx_frame(5'b11111, 1'b0);
		bus_wr(OFS_CMD, 16'h0424);
		@(posedge clk);
		{tx_cmd, nb, nc, rx_busy, tx_req} <= {4'h8, 11'd8, 5'd2, 2'b11};
		wait_n(20);
		chk("go busy", gos, 0);
		@(posedge clk);
		rx_busy <= 1'b0;
		tx_frame(4'h8, 11'd8, 5'd2, 1'b1);
		chk("attempts", gos, 3);
		tx_frame(4'h1, 11'd1515, 5'd0, 1'b1);
		tx_frame(4'h1, 11'd1514, 5'd0, 1'b0);
		tx_frame(4'h2, 11'd8, 5'd1, 1'b1);
		tx_frame(4'h4, 11'd8, 5'd1, 1'b0);
		g = gos;
		tx_frame(4'h4, 11'd8, 5'd16, 1'b1);
		chk("abandon tries", gos - g, 16);
		complete_run;
	end
endmodule
